// >>> mdc_pkg.sv
package mdc_pkg;
   // Word layout, MSB first
   localparam int unsigned WORD_BITS     = 32;
   localparam int unsigned VAL_BITS      = 14;
   localparam int unsigned NUM_CH        = 32;
   localparam int unsigned CMD_MSB       = 31;
   localparam int unsigned CMD_LSB       = 29;
   localparam int unsigned CHF_MSB       = 28;
   localparam int unsigned CHF_LSB       = 23;
   localparam int unsigned VAL_MSB       = 15;
   localparam int unsigned VAL_LSB       = 2;
   // Command codes
   localparam logic [2:0]  CMD_NOP       = 3'h0;
   localparam logic [2:0]  CMD_WRITE     = 3'h1;
   localparam logic [2:0]  CMD_LOAD      = 3'h2;
   localparam logic [2:0]  CMD_THRU      = 3'h3;
   localparam logic [2:0]  CMD_READ      = 3'h4;
   localparam logic [2:0]  CMD_CLEAR     = 3'h7;
   // Channel field values
   localparam logic [5:0]  CHF_OFFSET    = 6'h20;
   localparam logic [5:0]  CHF_ALL       = 6'h3f;
   localparam logic [13:0] VAL_RESET     = 14'h0000;
   // Pin sync order: sel, clear_n, load_n, din, sclk, cs_n
   localparam logic [5:0]  PIN_IDLE      = 6'h3b;
   localparam int unsigned PIN_CS        = 0;
   localparam int unsigned PIN_SCLK      = 1;
   localparam int unsigned PIN_DIN       = 2;
   localparam int unsigned PIN_LOAD      = 3;
   localparam int unsigned PIN_CLEAR     = 4;
   localparam int unsigned PIN_SEL       = 5;
   // Timing
   localparam int unsigned CLK_PERIOD_NS  = 4;
   localparam int unsigned SCLK_PERIOD_NS = 64;
   localparam logic [7:0]  SCLK_HALF      =
      8'(SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS));
   localparam logic [7:0]  CLEAR_CYCLES   = 8'h28;
   localparam logic [7:0]  HOST_CLR_WAIT  = 8'h30;
   localparam logic [7:0]  CS_GAP_CYCLES  = 8'h10;
   // Host link states
   typedef enum logic [2:0] {
      HS_IDLE, HS_HIGH, HS_LOW, HS_END, HS_GAP
   } mdc_host_state_t;
endpackage

// >>> mdc_link_if.sv
`timescale 1ns/1ps
interface mdc_link_if;
   logic cs_n;
   logic sclk;
   logic din;
   logic dout;
   logic load_all_n;
   logic clear_all_n;
   logic iface_sel;

   // Documented device end
   modport dev (
      input  cs_n, sclk, din, load_all_n, clear_all_n, iface_sel,
      output dout
   );
   // Serial host end
   modport host (
      output cs_n, sclk, din, load_all_n, clear_all_n, iface_sel,
      input  dout
   );
endinterface

// >>> mdc_dev.sv
`timescale 1ns/1ps
module mdc_dev (
   // Clock and reset
   input  wire logic                       clk_i,
   input  wire logic                       rst_n_i,
   // Serial link
   mdc_link_if.dev                         link,
   // Converter codes and clear busy flag
   output logic [mdc_pkg::NUM_CH-1:0][13:0] chan_value_o,
   output logic [13:0]                     offset_value_o,
   output logic                            clear_busy_o
);

   logic [5:0]                      pin_s1_reg;
   logic [5:0]                      pin_s2_reg;
   logic                            sclk_d_reg;
   logic [5:0]                      bit_cnt_reg;
   logic [31:0]                     shift_reg;
   logic [7:0]                      busy_cnt_reg;
   logic [13:0]                     in_mem [mdc_pkg::NUM_CH];
   logic [13:0]                     off_in_reg;
   logic                            sclk_fall;
   logic                            word_done;
   logic [31:0]                     word;
   logic [2:0]                      cmd;
   logic [5:0]                      chf;
   logic [13:0]                     val;
   logic                            clr_pin;
   logic                            clr_cmd;
   logic [31:0]                     rd_word;

   // Channel field hits channel idx or all
   function automatic logic chan_hit(input logic [5:0] f,
                                     input logic [4:0] idx);
      chan_hit = (f == mdc_pkg::CHF_ALL) || (f == {1'b0, idx});
   endfunction

   // Two-flop sync of all pins
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pin_s1_reg <= mdc_pkg::PIN_IDLE;
         pin_s2_reg <= mdc_pkg::PIN_IDLE;
         sclk_d_reg <= 1'b1;
      end
      else
      begin
         pin_s1_reg <= {link.iface_sel, link.clear_all_n,
                        link.load_all_n, link.din, link.sclk, link.cs_n};
         pin_s2_reg <= pin_s1_reg;
         sclk_d_reg <= pin_s2_reg[mdc_pkg::PIN_SCLK];
      end
   end

   // Edge detect and word decode
   assign sclk_fall = sclk_d_reg & ~pin_s2_reg[mdc_pkg::PIN_SCLK];
   assign word      = {shift_reg[30:0], pin_s2_reg[mdc_pkg::PIN_DIN]};
   assign word_done = sclk_fall && !pin_s2_reg[mdc_pkg::PIN_CS]
                      && (bit_cnt_reg == 6'h1f) && (busy_cnt_reg == 8'h00);
   assign cmd       = word[mdc_pkg::CMD_MSB:mdc_pkg::CMD_LSB];
   assign chf       = word[mdc_pkg::CHF_MSB:mdc_pkg::CHF_LSB];
   assign val       = word[mdc_pkg::VAL_MSB:mdc_pkg::VAL_LSB];
   assign clr_pin   = !pin_s2_reg[mdc_pkg::PIN_CLEAR];
   assign clr_cmd   = word_done && (cmd == mdc_pkg::CMD_CLEAR);
   assign rd_word   = {cmd, chf, 7'h00,
                       (chf == mdc_pkg::CHF_OFFSET) ? offset_value_o
                                                    : chan_value_o[chf[4:0]],
                       2'b00};

   // Bit counter with framing modes
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         bit_cnt_reg <= 6'h00;
      else if (busy_cnt_reg != 8'h00 || clr_pin)
         bit_cnt_reg <= 6'h00;
      else if (pin_s2_reg[mdc_pkg::PIN_CS])
      begin
         if (pin_s2_reg[mdc_pkg::PIN_SEL])
            bit_cnt_reg <= 6'h00;
         // Processor framing keeps the count across select high
      end
      else if (sclk_fall)
         bit_cnt_reg <= (bit_cnt_reg == 6'h1f) ? 6'h00
                                               : bit_cnt_reg + 6'h01;
   end

   // Shift path feeds read-back and daisy chain
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         shift_reg <= 32'h0000_0000;
      else if (word_done && cmd == mdc_pkg::CMD_READ
               && chf != mdc_pkg::CHF_ALL)
         shift_reg <= rd_word;
      else if (sclk_fall && !pin_s2_reg[mdc_pkg::PIN_CS]
               && busy_cnt_reg == 8'h00)
         shift_reg <= word;
   end

   // Serial data out register
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         link.dout <= 1'b0;
      else
         link.dout <= shift_reg[31];
   end

   // Clear sequence timer
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         busy_cnt_reg <= 8'h00;
         clear_busy_o <= 1'b0;
      end
      else if (clr_pin || clr_cmd)
      begin
         busy_cnt_reg <= mdc_pkg::CLEAR_CYCLES;
         clear_busy_o <= 1'b1;
      end
      else
      begin
         busy_cnt_reg <= (busy_cnt_reg != 8'h00) ? busy_cnt_reg - 8'h01
                                                 : 8'h00;
         clear_busy_o <= (busy_cnt_reg > 8'h01);
      end
   end

   // Offset channel registers
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         off_in_reg     <= mdc_pkg::VAL_RESET;
         offset_value_o <= mdc_pkg::VAL_RESET;
      end
      else if (clr_pin || clr_cmd)
      begin
         off_in_reg     <= mdc_pkg::VAL_RESET;
         offset_value_o <= mdc_pkg::VAL_RESET;
      end
      else
      begin
         if (!pin_s2_reg[mdc_pkg::PIN_LOAD])
            offset_value_o <= off_in_reg;
         if (word_done && chf == mdc_pkg::CHF_OFFSET)
         begin
            case (cmd)
               mdc_pkg::CMD_WRITE: off_in_reg <= val;
               mdc_pkg::CMD_LOAD:  offset_value_o <= off_in_reg;
               mdc_pkg::CMD_THRU:
               begin
                  off_in_reg     <= val;
                  offset_value_o <= val;
               end
               default: ;
            endcase
         end
      end
   end

   // Regular channel double buffers
   generate
      for (genvar i = 0; i < mdc_pkg::NUM_CH; i++)
      begin : g_ch
         always_ff @(posedge clk_i or negedge rst_n_i)
         begin
            if (!rst_n_i)
            begin
               in_mem[i]       <= mdc_pkg::VAL_RESET;
               chan_value_o[i] <= mdc_pkg::VAL_RESET;
            end
            else if (clr_pin || clr_cmd)
            begin
               in_mem[i]       <= mdc_pkg::VAL_RESET;
               chan_value_o[i] <= mdc_pkg::VAL_RESET;
            end
            else
            begin
               if (!pin_s2_reg[mdc_pkg::PIN_LOAD])
                  chan_value_o[i] <= in_mem[i];
               if (word_done && chan_hit(chf, 5'(i)))
               begin
                  case (cmd)
                     mdc_pkg::CMD_WRITE: in_mem[i] <= val;
                     mdc_pkg::CMD_LOAD:
                        chan_value_o[i] <= in_mem[i];
                     mdc_pkg::CMD_THRU:
                     begin
                        in_mem[i]       <= val;
                        chan_value_o[i] <= val;
                     end
                     default: ;
                  endcase
               end
            end
         end
      end
   endgenerate

endmodule // mdc_dev

// >>> mdc_host.sv
`timescale 1ns/1ps
module mdc_host (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   // Serial link
   mdc_link_if.host         link,
   // Command request
   input  wire logic        cmd_valid_i,
   input  wire logic [31:0] cmd_word_i,
   output logic             cmd_ready_o,
   // Received word
   output logic [31:0]      rx_word_o,
   output logic             rx_valid_o,
   // Pin requests
   input  wire logic        load_req_i,
   input  wire logic        clear_req_i,
   input  wire logic        dsp_mode_i
);

   mdc_pkg::mdc_host_state_t state_reg;
   logic [7:0]              div_cnt_reg;
   logic [7:0]              wait_cnt_reg;
   logic [5:0]              bit_cnt_reg;
   logic [31:0]             tx_reg;
   logic [31:0]             rx_reg;
   logic                    dout_s1_reg;
   logic                    dout_s2_reg;

   // Static pins; load high unless asked
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         link.load_all_n  <= 1'b1;
         link.clear_all_n <= 1'b1;
         link.iface_sel   <= 1'b1;
      end
      else
      begin
         link.load_all_n  <= !load_req_i;
         link.clear_all_n <= !clear_req_i;
         link.iface_sel   <= !dsp_mode_i;
      end
   end

   // Data-out sync
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         dout_s1_reg <= 1'b0;
         dout_s2_reg <= 1'b0;
      end
      else
      begin
         dout_s1_reg <= link.dout;
         dout_s2_reg <= dout_s1_reg;
      end
   end

   // Frame engine; waits out any clear
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_reg    <= mdc_pkg::HS_IDLE;
         div_cnt_reg  <= 8'h00;
         wait_cnt_reg <= 8'h00;
         bit_cnt_reg  <= 6'h00;
         tx_reg       <= 32'h0000_0000;
         rx_reg       <= 32'h0000_0000;
         rx_word_o    <= 32'h0000_0000;
         rx_valid_o   <= 1'b0;
         cmd_ready_o  <= 1'b0;
         link.cs_n    <= 1'b1;
         link.sclk    <= 1'b1;
         link.din     <= 1'b0;
      end
      else
      begin
         rx_valid_o <= 1'b0;
         if (clear_req_i)
            wait_cnt_reg <= mdc_pkg::HOST_CLR_WAIT;
         else if (wait_cnt_reg != 8'h00 && state_reg == mdc_pkg::HS_IDLE)
            wait_cnt_reg <= wait_cnt_reg - 8'h01;
         if (div_cnt_reg != 8'h00)
            div_cnt_reg <= div_cnt_reg - 8'h01;
         case (state_reg)
            mdc_pkg::HS_IDLE:
            begin
               cmd_ready_o <= !clear_req_i && wait_cnt_reg == 8'h00
                              && !cmd_ready_o;
               if (cmd_valid_i && cmd_ready_o)
               begin
                  cmd_ready_o <= 1'b0;
                  tx_reg      <= {cmd_word_i[30:0], 1'b0};
                  link.din    <= cmd_word_i[31];
                  link.cs_n   <= 1'b0;
                  bit_cnt_reg <= 6'h00;
                  div_cnt_reg <= mdc_pkg::SCLK_HALF;
                  if (cmd_word_i[31:29] == mdc_pkg::CMD_CLEAR)
                     wait_cnt_reg <= mdc_pkg::HOST_CLR_WAIT;
                  state_reg   <= mdc_pkg::HS_HIGH;
               end
            end
            mdc_pkg::HS_HIGH:
               if (div_cnt_reg == 8'h00)
               begin
                  rx_reg      <= {rx_reg[30:0], dout_s2_reg};
                  link.sclk   <= 1'b0;
                  div_cnt_reg <= mdc_pkg::SCLK_HALF;
                  state_reg   <= mdc_pkg::HS_LOW;
               end
            mdc_pkg::HS_LOW:
               if (div_cnt_reg == 8'h00)
               begin
                  link.sclk   <= 1'b1;
                  div_cnt_reg <= mdc_pkg::SCLK_HALF;
                  if (bit_cnt_reg == 6'h1f)
                     state_reg <= mdc_pkg::HS_END;
                  else
                  begin
                     link.din    <= tx_reg[31];
                     tx_reg      <= {tx_reg[30:0], 1'b0};
                     bit_cnt_reg <= bit_cnt_reg + 6'h01;
                     state_reg   <= mdc_pkg::HS_HIGH;
                  end
               end
            mdc_pkg::HS_END:
               if (div_cnt_reg == 8'h00)
               begin
                  link.cs_n   <= 1'b1;
                  rx_word_o   <= rx_reg;
                  rx_valid_o  <= 1'b1;
                  div_cnt_reg <= mdc_pkg::CS_GAP_CYCLES;
                  state_reg   <= mdc_pkg::HS_GAP;
               end
            mdc_pkg::HS_GAP:
               if (div_cnt_reg == 8'h00)
                  state_reg <= mdc_pkg::HS_IDLE;
            default:
               state_reg <= mdc_pkg::HS_IDLE;
         endcase
      end
   end

endmodule // mdc_host

// >>> mdc_props.sv
`timescale 1ns/1ps
module mdc_props (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Link signals
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic din,
   input wire logic dout,
   input wire logic load_all_n,
   input wire logic clear_all_n,
   input wire logic iface_sel
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   logic       sclk_last_reg;
   logic [5:0] fall_cnt_reg;

   // Falling serial clock edges in the current frame
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         sclk_last_reg <= 1'b1;
         fall_cnt_reg  <= 6'h00;
      end
      else
      begin
         sclk_last_reg <= sclk;
         if (cs_n)
            fall_cnt_reg <= 6'h00;
         else if (sclk_last_reg && !sclk)
            fall_cnt_reg <= fall_cnt_reg + 6'h01;
      end
   end

   chk_clock_idle_high:
      assert property (cs_n && $past(cs_n) |-> sclk)
      else $error("serial clock not high between frames");
   chk_select_lead_time:
      assert property ($fell(cs_n) |-> sclk [*8])
      else $error("serial clock fell too soon after select");
   chk_clock_low_phase:
      assert property ($fell(sclk) |-> !sclk [*8])
      else $error("serial clock low phase too short");
   chk_clock_high_phase:
      assert property ($rose(sclk) && !cs_n |-> sclk [*8])
      else $error("serial clock high phase too short");
   chk_data_held_low:
      assert property (!sclk && $past(!sclk) |-> $stable(din))
      else $error("data moved while serial clock low");
   chk_frame_bit_count:
      assert property ($rose(cs_n) |-> fall_cnt_reg == 6'h20)
      else $error("frame did not carry 32 clock falls");
   chk_select_gap_min:
      assert property ($rose(cs_n) |-> cs_n [*8])
      else $error("select high gap too short");
   chk_mode_frame_stable:
      assert property (!cs_n && $past(!cs_n) |-> $stable(iface_sel))
      else $error("framing mode changed inside a frame");

   // Main scenarios
   cov_frame_done: cover property ($rose(cs_n));
   cov_load_pin:   cover property ($fell(load_all_n));
   cov_clear_pin:  cover property ($fell(clear_all_n));
   cov_proc_frame: cover property (!iface_sel && $fell(cs_n));
   cov_dout_high:  cover property ($rose(dout));
endmodule // mdc_props

// >>> mdc_bench.sv
`timescale 1ns/1ps
module mdc_bench;
   logic                             clk_i;
   logic                             rst_n_i;
   logic                             cmd_valid_i;
   logic [31:0]                      cmd_word_i;
   logic                             cmd_ready_o;
   logic [31:0]                      rx_word_o;
   logic [31:0]                      rx_got;
   logic                             rx_valid_o;
   logic                             load_req_i;
   logic                             clear_req_i;
   logic                             dsp_mode_i;
   logic [mdc_pkg::NUM_CH-1:0][13:0] chan_value_o;
   logic [13:0]                      offset_value_o;
   logic                             clear_busy_o;
   int                               bad_count;
   int                               n_tests;
   logic                             hung;

   mdc_link_if link ();

   mdc_dev mdc_dev_inst (
      .clk_i          (clk_i),
      .rst_n_i        (rst_n_i),
      .link           (link.dev),
      .chan_value_o   (chan_value_o),
      .offset_value_o (offset_value_o),
      .clear_busy_o   (clear_busy_o)
   );

   mdc_host mdc_host_inst (
      .clk_i       (clk_i),
      .rst_n_i     (rst_n_i),
      .link        (link.host),
      .cmd_valid_i (cmd_valid_i),
      .cmd_word_i  (cmd_word_i),
      .cmd_ready_o (cmd_ready_o),
      .rx_word_o   (rx_word_o),
      .rx_valid_o  (rx_valid_o),
      .load_req_i  (load_req_i),
      .clear_req_i (clear_req_i),
      .dsp_mode_i  (dsp_mode_i)
   );

   mdc_props mdc_props_inst (
      .clk_i       (clk_i),
      .rst_n_i     (rst_n_i),
      .cs_n        (link.cs_n),
      .sclk        (link.sclk),
      .din         (link.din),
      .dout        (link.dout),
      .load_all_n  (link.load_all_n),
      .clear_all_n (link.clear_all_n),
      .iface_sel   (link.iface_sel)
   );

   // Clock generator
   initial
   begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   // Command word assembly
   function automatic logic [31:0] wd(logic [2:0] c, logic [5:0] f,
                                      logic [13:0] v);
      return {c, f, 7'h00, v, 2'b00};
   endfunction

   task automatic report_and_stop();
      $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One frame through the host, waits for the returned word
   task automatic send(logic [31:0] w);
      int i;
      // After a hang, skip frames and run on to the report
      if (hung)
         return;
      @(posedge clk_i);
      cmd_valid_i <= 1'b1;
      cmd_word_i  <= w;
      for (i = 0; i < 2000; i++)
      begin
         @(posedge clk_i);
         if (cmd_ready_o === 1'b1)
            break;
      end
      cmd_valid_i <= 1'b0;
      for (i = 0; i < 2000; i++)
      begin
         @(posedge clk_i);
         if (rx_valid_o === 1'b1)
            break;
      end
      if (i == 2000)
      begin
         bad_count++;
         hung = 1'b1;
      end
      rx_got = rx_word_o;
      repeat (4) @(posedge clk_i);
   endtask

   // Pin pulse: load when sel is 0, clear when 1
   task automatic pin(bit sel);
      @(posedge clk_i);
      if (sel)
         clear_req_i <= 1'b1;
      else
         load_req_i <= 1'b1;
      repeat (10) @(posedge clk_i);
      clear_req_i <= 1'b0;
      load_req_i  <= 1'b0;
      repeat (6) @(posedge clk_i);
   endtask

   // Main sequence
   initial
   begin
      rst_n_i     = 1'b0;
      cmd_valid_i = 1'b0;
      cmd_word_i  = 32'h0000_0000;
      load_req_i  = 1'b0;
      clear_req_i = 1'b0;
      dsp_mode_i  = 1'b0;
      hung        = 1'b0;
      bad_count   = 0;
      n_tests     = 0;
      repeat (20) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      chk("chan0 reset", 32'h0, 32'(chan_value_o[0]));
      send(wd(mdc_pkg::CMD_WRITE, 6'h05, 14'h1234));
      chk("chan5 input only", 32'h0, 32'(chan_value_o[5]));
      send(wd(mdc_pkg::CMD_LOAD, 6'h05, 14'h3fff));
      chk("chan5 loaded", 32'h1234, 32'(chan_value_o[5]));
      send(wd(mdc_pkg::CMD_WRITE, mdc_pkg::CHF_ALL, 14'h0abc));
      send(wd(mdc_pkg::CMD_WRITE, mdc_pkg::CHF_OFFSET, 14'h1000));
      send(wd(mdc_pkg::CMD_LOAD, mdc_pkg::CHF_ALL, 14'h0000));
      chk("chan31 load all", 32'h0abc, 32'(chan_value_o[31]));
      chk("chan5 load all", 32'h0abc, 32'(chan_value_o[5]));
      chk("offset kept", 32'h0, 32'(offset_value_o));
      pin(1'b0);
      chk("offset load pin", 32'h1000, 32'(offset_value_o));
      send(wd(mdc_pkg::CMD_THRU, mdc_pkg::CHF_OFFSET, 14'h2000));
      chk("offset thru", 32'h2000, 32'(offset_value_o));
      send(wd(mdc_pkg::CMD_READ, 6'h07, 14'h0000));
      send(wd(mdc_pkg::CMD_NOP, 6'h00, 14'h0155));
      chk("read back", wd(3'h4, 6'h07, 14'h0abc), rx_got);
      send(wd(mdc_pkg::CMD_NOP, 6'h00, 14'h0000));
      chk("chain word", wd(3'h0, 6'h00, 14'h0155), rx_got);
      // Read of the all-channel field only passes the word on
      send(wd(mdc_pkg::CMD_READ, mdc_pkg::CHF_ALL, 14'h0000));
      send(wd(mdc_pkg::CMD_NOP, 6'h00, 14'h0000));
      chk("read all refused", wd(3'h4, 6'h3f, 14'h0000), rx_got);
      send(wd(mdc_pkg::CMD_CLEAR, mdc_pkg::CHF_ALL, 14'h0000));
      chk("clear busy", 32'h1, 32'(clear_busy_o));
      chk("offset cleared", 32'h0, 32'(offset_value_o));
      chk("chan5 cleared", 32'h0, 32'(chan_value_o[5]));
      // Offset range code restored after the clear
      send(wd(mdc_pkg::CMD_THRU, mdc_pkg::CHF_OFFSET, 14'h1000));
      chk("offset rewritten", 32'h1000, 32'(offset_value_o));
      dsp_mode_i <= 1'b1;
      send(wd(mdc_pkg::CMD_THRU, 6'h03, 14'h3fff));
      chk("chan3 proc mode", 32'h3fff, 32'(chan_value_o[3]));
      dsp_mode_i <= 1'b0;
      pin(1'b1);
      chk("chan3 pin clear", 32'h0, 32'(chan_value_o[3]));
      report_and_stop();
   end
endmodule // mdc_bench
